// >>> hw/board_irq_defines.vh
// Constants for the board interrupt encoder: register indexes, fields, codes
`ifndef BOARD_IRQ_DEFINES_VH
`define BOARD_IRQ_DEFINES_VH

// ----------------------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_SOURCE_STATUS    32'h0B900002
`define IDX_PCI_LINE_CTRL    32'hB9000004
`define IDX_LEVEL_MASK       32'h0B900003

// ----------------------------------------------------------------------------
// Reset values and implemented-bit masks
// ----------------------------------------------------------------------------
`define STATUS_RESET         16'h0000
`define STATUS_IMPL          16'h77FF
`define PCI_CTRL_RESET       16'h0000
`define PCI_CTRL_IMPL        16'h0707
`define LEVEL_MASK_RESET     16'h77FF
`define LEVEL_MASK_IMPL      16'h77FF
`define LEVEL_CAPABLE        16'h70FF

// ----------------------------------------------------------------------------
// Source bit positions (shared by status and level mask)
// ----------------------------------------------------------------------------
`define BIT_SC_ERROR         14
`define BIT_SC_RECEIVE       13
`define BIT_SC_TRANSMIT      12
`define BIT_USB_HOST         10
`define BIT_CARD_SLOT        9
`define BIT_GRAPHICS         8
`define BIT_EXP3             7
`define BIT_EXP2             6
`define BIT_EXP1             5
`define BIT_EXP0             4
`define BIT_USB_POWER        3
`define BIT_BOARD_MCU        2
`define BIT_UART_B           1
`define BIT_UART_A           0

// ----------------------------------------------------------------------------
// Line-control fields
// ----------------------------------------------------------------------------
`define SEL_LSB              0
`define SEL_MSB              2

// ----------------------------------------------------------------------------
// Level codes
// ----------------------------------------------------------------------------
`define CODE_EXP3            4'h1
`define CODE_SC_ERROR        4'h2
`define CODE_UART_A          4'h3
`define CODE_BOARD_MCU       4'h4
`define CODE_EXP2            4'h5
`define CODE_UART_B          4'h7
`define CODE_EXP1            4'h9
`define CODE_SC_TRANSMIT     4'hA
`define CODE_SC_RECEIVE      4'hB
`define CODE_USB_POWER       4'hC
`define CODE_EXP0            4'hD
`define CODE_IDLE            4'hF

// ----------------------------------------------------------------------------
// Line select values
// ----------------------------------------------------------------------------
`define SEL_CBA              3'h0
`define SEL_CAB              3'h1
`define SEL_BAC              3'h2
`define SEL_BCA              3'h7
`define SEL_CAB2             3'h4
`define SEL_CBA2             3'h5

`endif

// >>> hw/level_code_encoder.v
// Priority encoder from pending sources to the processor level code
`timescale 1ns/10ps
module level_code_encoder (
  input  wire [15:0] request,
  input  wire [15:0] mask,
  output wire [3:0]  code
);
`include "board_irq_defines.vh"

  // --------------------------------------------------------------------------
  // Highest level wins; PCI-attached sources never reach the code
  // --------------------------------------------------------------------------
  function [3:0] pick;
    input [15:0] p;
    begin
      if (p[`BIT_EXP3])              pick = `CODE_EXP3;         // see (RULE2)
      else if (p[`BIT_SC_ERROR])     pick = `CODE_SC_ERROR;     // see (RULE2)
      else if (p[`BIT_UART_A])       pick = `CODE_UART_A;       // see (RULE2)
      else if (p[`BIT_BOARD_MCU])    pick = `CODE_BOARD_MCU;    // see (RULE3)
      else if (p[`BIT_EXP2])         pick = `CODE_EXP2;         // see (RULE3)
      else if (p[`BIT_UART_B])       pick = `CODE_UART_B;       // see (RULE3)
      else if (p[`BIT_EXP1])         pick = `CODE_EXP1;         // see (RULE4)
      else if (p[`BIT_SC_TRANSMIT])  pick = `CODE_SC_TRANSMIT;  // see (RULE4)
      else if (p[`BIT_SC_RECEIVE])   pick = `CODE_SC_RECEIVE;   // see (RULE4)
      else if (p[`BIT_USB_POWER])    pick = `CODE_USB_POWER;    // see (RULE5)
      else if (p[`BIT_EXP0])         pick = `CODE_EXP0;         // see (RULE5)
      else                           pick = `CODE_IDLE;         // see (RULE21)
    end
  endfunction

  assign code = pick(request & ~mask & `LEVEL_CAPABLE);  // see (RULE19) see (RULE6)

endmodule

// >>> hw/pci_line_router.v
// Maps the three PCI-attached requests onto lines A, B and C
`timescale 1ns/10ps
module pci_line_router (
  input  wire       card_slot_req,
  input  wire       graphics_req,
  input  wire       usb_host_req,
  input  wire [2:0] line_select,
  input  wire [2:0] line_mask,
  output reg  [2:0] line_assert
);
`include "board_irq_defines.vh"

  wire cs;
  wire gr;
  wire uh;

  // line_mask bit 2 = USB host, bit 1 = card slot, bit 0 = graphics
  assign uh = usb_host_req  & ~line_mask[2];  // see (RULE15)
  assign cs = card_slot_req & ~line_mask[1];  // see (RULE15)
  assign gr = graphics_req  & ~line_mask[0];  // see (RULE15)

  // --------------------------------------------------------------------------
  // line_assert is {C, B, A}
  // --------------------------------------------------------------------------
  always @* begin
    case (line_select)
      `SEL_CBA:  line_assert = {uh, gr, cs};  // see (RULE16)
      `SEL_CAB:  line_assert = {gr, uh, cs};  // see (RULE16)
      `SEL_BAC:  line_assert = {uh, cs, gr};  // see (RULE17)
      `SEL_BCA:  line_assert = {gr, cs, uh};  // see (RULE17)
      `SEL_CAB2: line_assert = {cs, uh, gr};  // see (RULE18)
      `SEL_CBA2: line_assert = {cs, gr, uh};  // see (RULE18)
      default:   line_assert = 3'h0;          // see (RULE18)
    endcase
  end

endmodule

// >>> hw/board_interrupt_encoder.v
// Board interrupt encoder: pin sync, status, masks, level code, PCI lines, APB
//
// Summary of operation
// (RULE1) Merge board requests into one level code
// (RULE2) Expansion 3, card error, UART A codes
// (RULE3) Board MCU, expansion 2, UART B codes
// (RULE4) Expansion 1, card transmit, receive codes
// (RULE5) USB power and expansion 0 codes
// (RULE6) PCI-attached controllers drive PCI lines instead
// (RULE7) Expansion boards drive requests active low
// (RULE8) Status bits 14-12 flag card requests
// (RULE9) Status bits 10-8 flag PCI controllers
// (RULE10) Status bits 7-4 flag expansion requests
// (RULE11) Status bits 3-0 flag power, MCU, UARTs
// (RULE12) Read-only status follows sources, resets zero
// (RULE13) Overcurrent cleared through USB control register; here it clears only when the source withdraws
// (RULE14) Reserved bits read zero, ignore writes
// (RULE15) Line-control bits 10-8 mask PCI lines
// (RULE16) Select 000 and 001 routings
// (RULE17) Select 010 and 111 routings
// (RULE18) Select 100, 101 routings; others drive none
// (RULE19) Level mask register resets all ones
// (RULE20) Masked sources still set status
// (RULE21) Highest pending level wins, idle 1111
// (RULE22) Requests are levels; drop when withdrawn
`timescale 1ns/10ps
module board_interrupt_encoder (
  input  wire        core_clk,
  input  wire        rstn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [3:0]  expansion_request_n,
  input  wire        smartcard_error_request_n,
  input  wire        smartcard_transmit_request_n,
  input  wire        smartcard_receive_request_n,
  input  wire        uart_a_request,
  input  wire        uart_b_request,
  input  wire        board_mcu_request_n,
  input  wire        usb_power_request,
  input  wire        card_slot_request_n,
  input  wire        graphics_request_n,
  input  wire        usb_host_request_n,
  output reg  [3:0]  interrupt_level_code,
  output reg         pci_line_a_n,
  output reg         pci_line_b_n,
  output reg         pci_line_c_n
);
`include "board_irq_defines.vh"

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  // Only the low 30 bits of each index fit a 32-bit byte address, so the
  // top bits of an index are cut before it meets the word address
  localparam [31:0] STATUS_IDX = `IDX_SOURCE_STATUS;
  localparam [31:0] LINE_IDX   = `IDX_PCI_LINE_CTRL;
  localparam [31:0] MASK_IDX   = `IDX_LEVEL_MASK;

  function [1:0] decode;
    input [31:0] a;
    begin
      if (a[1:0] != 2'h0)
        decode = 2'h0;
      else if (a[31:2] == STATUS_IDX[29:0])
        decode = 2'h1;
      else if (a[31:2] == LINE_IDX[29:0])
        decode = 2'h2;
      else if (a[31:2] == MASK_IDX[29:0])
        decode = 2'h3;
      else
        decode = 2'h0;
    end
  endfunction

  // Byte-lane merge of a 16-bit register, kept only in implemented bits
  function [15:0] merge;
    input [15:0] old;
    input [15:0] wd;
    input [1:0]  strb;
    input [15:0] impl;
    reg   [15:0] m;
    begin
      m     = {{8{strb[1]}}, {8{strb[0]}}};
      merge = ((old & ~m) | (wd & m)) & impl;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Request pins, gathered in status bit order, active high
  // --------------------------------------------------------------------------
  wire [15:0] raw_req;

  assign raw_req[15]               = 1'b0;
  assign raw_req[`BIT_SC_ERROR]    = ~smartcard_error_request_n;
  assign raw_req[`BIT_SC_RECEIVE]  = ~smartcard_receive_request_n;
  assign raw_req[`BIT_SC_TRANSMIT] = ~smartcard_transmit_request_n;
  assign raw_req[11]               = 1'b0;
  assign raw_req[`BIT_USB_HOST]    = ~usb_host_request_n;
  assign raw_req[`BIT_CARD_SLOT]   = ~card_slot_request_n;
  assign raw_req[`BIT_GRAPHICS]    = ~graphics_request_n;
  assign raw_req[`BIT_EXP3]        = ~expansion_request_n[3];  // see (RULE7)
  assign raw_req[`BIT_EXP2]        = ~expansion_request_n[2];  // see (RULE7)
  assign raw_req[`BIT_EXP1]        = ~expansion_request_n[1];  // see (RULE7)
  assign raw_req[`BIT_EXP0]        = ~expansion_request_n[0];  // see (RULE7)
  assign raw_req[`BIT_USB_POWER]   = usb_power_request;
  assign raw_req[`BIT_BOARD_MCU]   = ~board_mcu_request_n;
  assign raw_req[`BIT_UART_B]      = uart_b_request;
  assign raw_req[`BIT_UART_A]      = uart_a_request;

  // --------------------------------------------------------------------------
  // Synchroniser and registers
  // --------------------------------------------------------------------------
  reg  [15:0] sync1_r;
  reg  [15:0] sync2_r;
  reg  [15:0] status_r;
  reg  [15:0] pci_ctrl_r;
  reg  [15:0] level_mask_r;
  reg  [15:0] pci_ctrl_nxt;
  reg  [15:0] level_mask_nxt;
  reg  [15:0] rdata_nxt;
  wire [1:0]  sel_reg;
  wire        setup;
  wire        commit;
  wire [3:0]  code_nxt;
  wire [2:0]  line_nxt;

  assign sel_reg = decode(paddr);
  assign setup   = psel & ~penable;
  assign commit  = psel & penable & pready;

  // Pins are asynchronous; two flops before any logic reads them
  always @(posedge core_clk) begin
    if (!rstn) begin
      sync1_r <= 16'h0000;
      sync2_r <= 16'h0000;
    end else begin
      sync1_r <= raw_req;
      sync2_r <= sync1_r;
    end
  end

  // Status mirrors the live request; no software clear exists, the source
  // must withdraw, which also covers the overcurrent bit
  always @(posedge core_clk) begin
    if (!rstn)
      status_r <= `STATUS_RESET;                   // see (RULE12)
    else
      status_r <= sync2_r & `STATUS_IMPL;          // see (RULE8) see (RULE9) see (RULE10) see (RULE11) see (RULE20) see (RULE22) see (RULE13)
  end

  // --------------------------------------------------------------------------
  // Register writes; status is read only and ignores writes
  // --------------------------------------------------------------------------
  always @* begin
    pci_ctrl_nxt   = pci_ctrl_r;
    level_mask_nxt = level_mask_r;
    if (commit && pwrite && sel_reg == 2'h2)
      pci_ctrl_nxt = merge(pci_ctrl_r, pwdata[15:0], pstrb[1:0],
                           `PCI_CTRL_IMPL);        // see (RULE14)
    if (commit && pwrite && sel_reg == 2'h3)
      level_mask_nxt = merge(level_mask_r, pwdata[15:0], pstrb[1:0],
                             `LEVEL_MASK_IMPL);    // see (RULE14)
  end

  always @(posedge core_clk) begin
    if (!rstn) begin
      pci_ctrl_r   <= `PCI_CTRL_RESET;             // see (RULE15)
      level_mask_r <= `LEVEL_MASK_RESET;           // see (RULE19)
    end else begin
      pci_ctrl_r   <= pci_ctrl_nxt;
      level_mask_r <= level_mask_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // APB answer: one wait state, data captured in the setup cycle
  // --------------------------------------------------------------------------
  always @* begin
    case (sel_reg)
      2'h1:    rdata_nxt = status_r;               // see (RULE12)
      2'h2:    rdata_nxt = pci_ctrl_r;
      2'h3:    rdata_nxt = level_mask_r;
      default: rdata_nxt = 16'h0000;
    endcase
  end

  always @(posedge core_clk) begin
    if (!rstn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      if (setup)
        prdata <= {16'h0000, rdata_nxt};
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & (sel_reg == 2'h0);
    end
  end

  // --------------------------------------------------------------------------
  // Level code and PCI lines
  // --------------------------------------------------------------------------
  level_code_encoder u_encoder (
    .request (status_r),
    .mask    (level_mask_r),
    .code    (code_nxt)
  );

  pci_line_router u_router (
    .card_slot_req (status_r[`BIT_CARD_SLOT]),
    .graphics_req  (status_r[`BIT_GRAPHICS]),
    .usb_host_req  (status_r[`BIT_USB_HOST]),
    .line_select   (pci_ctrl_r[`SEL_MSB:`SEL_LSB]),
    .line_mask     (pci_ctrl_r[`BIT_USB_HOST:`BIT_GRAPHICS]),
    .line_assert   (line_nxt)
  );

  // Code is sourced from status and registered, so it drops one cycle after the status bit
  always @(posedge core_clk) begin
    if (!rstn) begin
      interrupt_level_code <= `CODE_IDLE;
      pci_line_a_n         <= 1'b1;
      pci_line_b_n         <= 1'b1;
      pci_line_c_n         <= 1'b1;
    end else begin
      interrupt_level_code <= code_nxt;            // see (RULE1) see (RULE21)
      pci_line_a_n         <= ~line_nxt[0];        // see (RULE6)
      pci_line_b_n         <= ~line_nxt[1];        // see (RULE6)
      pci_line_c_n         <= ~line_nxt[2];        // see (RULE6)
    end
  end

endmodule

// >>> verification/board_irq_props.sv
// Port-level assertions for the board interrupt encoder
`timescale 1ns/10ps
`include "board_irq_defines.vh"
module board_irq_props (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic [3:0]  expansion_request_n,
  input wire logic        smartcard_error_request_n,
  input wire logic        smartcard_transmit_request_n,
  input wire logic        smartcard_receive_request_n,
  input wire logic        uart_a_request,
  input wire logic        uart_b_request,
  input wire logic        board_mcu_request_n,
  input wire logic        usb_power_request,
  input wire logic        card_slot_request_n,
  input wire logic        graphics_request_n,
  input wire logic        usb_host_request_n,
  input wire logic [3:0]  interrupt_level_code,
  input wire logic        pci_line_a_n,
  input wire logic        pci_line_b_n,
  input wire logic        pci_line_c_n
);
  localparam logic [31:0] ST_ADDR = `IDX_SOURCE_STATUS * 4;
  localparam logic [31:0] PC_ADDR = `IDX_PCI_LINE_CTRL * 4;
  wire       pci_idle = card_slot_request_n & graphics_request_n & usb_host_request_n;
  wire [2:0] lines_n  = {pci_line_c_n, pci_line_b_n, pci_line_a_n};
  wire       lvl_idle = &expansion_request_n & smartcard_error_request_n & board_mcu_request_n
                      & smartcard_transmit_request_n & smartcard_receive_request_n
                      & !uart_a_request & !uart_b_request & !usb_power_request;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Eight quiet edges cover the two sync stages, the status register and the output register
  sequence quiet(s); s [*8]; endsequence
  sequence rd_done(a); psel && penable && pready && !pwrite && paddr == a; endsequence
  AST_RESET_IDLE: assert property ($rose(rstn) |-> interrupt_level_code == 4'hF && lines_n == 3'h7)
    else $error("outputs not idle after reset");
  AST_IDLE_CODE: assert property (quiet(lvl_idle) |=> interrupt_level_code == 4'hF)
    else $error("code not idle with no request");
  AST_NO_PCI_CODE: assert property (!(interrupt_level_code inside {4'h0, 4'h6, 4'h8, 4'hE}))
    else $error("unused level code driven");
  AST_EXP3_CODE: assert property (quiet(expansion_request_n[3]) |=> interrupt_level_code != 4'h1)
    else $error("expansion 3 code without request");
  AST_MCU_CODE: assert property (quiet(board_mcu_request_n) |=> interrupt_level_code != 4'h4)
    else $error("controller code without request");
  AST_RX_CODE: assert property (quiet(smartcard_receive_request_n) |=> interrupt_level_code != 4'hB)
    else $error("receive code without request");
  AST_EXP0_CODE: assert property (quiet(expansion_request_n[0]) |=> interrupt_level_code != 4'hD)
    else $error("expansion 0 code without request");
  AST_LINES_IDLE: assert property (quiet(pci_idle) |=> lines_n == 3'h7)
    else $error("PCI line driven without request");
  AST_STATUS_RSVD: assert property (rd_done(ST_ADDR) |-> !prdata[15] && !prdata[11])
    else $error("reserved status bit reads one");
  AST_CTRL_RSVD: assert property (rd_done(PC_ADDR) |-> (prdata[15:0] & 16'hF8F8) == 16'h0000)
    else $error("reserved line control bit reads one");
  AST_STATUS_IDLE: assert property (quiet(lvl_idle && pci_idle) ##0 rd_done(ST_ADDR) |-> prdata[15:0] == 16'h0000)
    else $error("status set with no request");
endmodule

// >>> verification/irq_sources.sv
// Peripheral request sources: turns wanted requests into pin levels
`timescale 1ns/10ps
module irq_sources (
  input  wire logic [15:0] want,
  output wire logic [3:0]  expansion_request_n,
  output wire logic        smartcard_error_request_n,
  output wire logic        smartcard_transmit_request_n,
  output wire logic        smartcard_receive_request_n,
  output wire logic        uart_a_request,
  output wire logic        uart_b_request,
  output wire logic        board_mcu_request_n,
  output wire logic        usb_power_request,
  output wire logic        card_slot_request_n,
  output wire logic        graphics_request_n,
  output wire logic        usb_host_request_n
);
  assign expansion_request_n          = ~want[7:4];
  assign smartcard_error_request_n    = ~want[14];
  assign smartcard_receive_request_n  = ~want[13];
  assign smartcard_transmit_request_n = ~want[12];
  assign usb_host_request_n           = ~want[10];
  assign card_slot_request_n          = ~want[9];
  assign graphics_request_n           = ~want[8];
  // Overcurrent request follows bit 3 of want directly, active high
  assign usb_power_request            = want[3];
  assign board_mcu_request_n          = ~want[2];
  assign uart_b_request               = want[1];
  assign uart_a_request               = want[0];
endmodule

// >>> verification/tb_board_interrupt_encoder.sv
// Self-checking bench for the board interrupt encoder
`timescale 1ns/10ps
`include "board_irq_defines.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb_board_interrupt_encoder;
  localparam logic [31:0] ST_ADDR = `IDX_SOURCE_STATUS * 4;
  localparam logic [31:0] PC_ADDR = `IDX_PCI_LINE_CTRL * 4;
  localparam logic [31:0] LM_ADDR = `IDX_LEVEL_MASK * 4;
  localparam logic [63:0] CODES   = 64'hF2BAFFFF159DC473;
  localparam logic [47:0] ROUTE   = {6'h18, 6'h3F, 6'h24, 6'h21, 6'h3F, 6'h12, 6'h09, 6'h06};
  logic        core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, smp = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, seed = 32'h08192ECB;
  logic [15:0] want = 0;
  logic [32:0] er;
  logic [6:0]  eo;
  logic [32:0] rdq[$];
  logic [6:0]  outq[$];
  logic        pready, pslverr, la_n, lb_n, lc_n, err_n, tx_n, rx_n, ua, ub, mcu_n, usbp, cs_n, gr_n, uh_n;
  logic [3:0]  ex_n, code, strb = 4'hF;
  int          bad_count = 0, checks_done = 0;

  board_interrupt_encoder board_interrupt_encoder_i (.core_clk(core_clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .expansion_request_n(ex_n), .smartcard_error_request_n(err_n),
    .smartcard_transmit_request_n(tx_n), .smartcard_receive_request_n(rx_n),
    .uart_a_request(ua), .uart_b_request(ub), .board_mcu_request_n(mcu_n),
    .usb_power_request(usbp), .card_slot_request_n(cs_n), .graphics_request_n(gr_n),
    .usb_host_request_n(uh_n), .interrupt_level_code(code), .pci_line_a_n(la_n),
    .pci_line_b_n(lb_n), .pci_line_c_n(lc_n));
  irq_sources irq_sources_i (.want(want), .expansion_request_n(ex_n),
    .smartcard_error_request_n(err_n), .smartcard_transmit_request_n(tx_n),
    .smartcard_receive_request_n(rx_n), .uart_a_request(ua), .uart_b_request(ub),
    .board_mcu_request_n(mcu_n), .usb_power_request(usbp), .card_slot_request_n(cs_n),
    .graphics_request_n(gr_n), .usb_host_request_n(uh_n));

  initial forever #2.5 core_clk = ~core_clk;

  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    @(posedge core_clk);
    if (!w) rdq.push_back(e);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge core_clk);
    end
    if (n == 50) bad_count++;
    psel <= 0;
    penable <= 0;
  endtask

  // Programs both masks, raises the sources and notes code, lines and status
  task automatic settle(input logic [15:0] v, input logic [15:0] lm, input logic [15:0] pc);
    logic [3:0] c;
    logic [2:0] ln;
    logic [5:0] rt;
    apb(1, LM_ADDR, {16'h0, lm}, 0);
    apb(1, PC_ADDR, {16'h0, pc}, 0);
    c = 4'hF;
    for (int i = 0; i < 16; i++)
      if (v[i] && !lm[i] && CODES[i*4+:4] < c) c = CODES[i*4+:4];
    ln = 3'h7;
    rt = ROUTE[pc[2:0]*6+:6];
    if (v[9] && !pc[9] && rt[5:4] != 2'd3) ln[rt[5:4]] = 0;
    if (v[8] && !pc[8] && rt[3:2] != 2'd3) ln[rt[3:2]] = 0;
    if (v[10] && !pc[10] && rt[1:0] != 2'd3) ln[rt[1:0]] = 0;
    want <= v;
    repeat (8) @(posedge core_clk);
    outq.push_back({c, ln});
    smp <= 1;
    @(posedge core_clk);
    smp <= 0;
    apb(0, ST_ADDR, 0, {17'h0, v});
  endtask

  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && rdq.size() > 0) begin
      er = rdq.pop_front();
      `CHK({pslverr, prdata}, er)
    end
    if (smp && outq.size() > 0) begin
      eo = outq.pop_front();
      `CHK({code, lc_n, lb_n, la_n}, eo)
    end
  end

  task automatic complete_run();
    $display("Mismatches %0d, comparisons %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge core_clk);
    bad_count++;
    complete_run();
  end

  initial begin
    repeat (16) @(posedge core_clk);
    rstn <= 1;
    repeat (10) @(posedge core_clk);
    apb(0, ST_ADDR, 0, 33'h0);
    apb(0, PC_ADDR, 0, 33'h0);
    apb(0, LM_ADDR, 0, 33'h77FF);
    apb(1, PC_ADDR, 32'hFFFFFFFF, 0);
    apb(0, PC_ADDR, 0, 33'h0707);
    // Low byte lane only: select clears, masks in the high lane stay
    strb <= 4'h1;
    apb(1, PC_ADDR, 32'h0, 0);
    strb <= 4'hF;
    apb(0, PC_ADDR, 0, 33'h0700);
    apb(1, ST_ADDR, 32'hFFFFFFFF, 0);
    apb(0, ST_ADDR, 0, 33'h0);
    apb(0, 32'h00000100, 0, {1'b1, 32'h0});
    // One source at a time, everything unmasked, walks every code and bit
    for (int i = 0; i < 16; i++)
      if (16'h77FF >> i & 1) settle(16'h1 << i, 16'h0, 16'h0);
    // Sparse random requests against random masks and line selects
    for (int i = 0; i < 64; i++)
      settle(16'(xs() & xs() & 32'h77FF), 16'(xs()), 16'(xs()));
    settle(16'h0, 16'h0, 16'h0);
    complete_run();
  end
endmodule

bind board_interrupt_encoder board_irq_props board_irq_props_i (.core_clk(core_clk),
  .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .expansion_request_n(expansion_request_n),
  .smartcard_error_request_n(smartcard_error_request_n),
  .smartcard_transmit_request_n(smartcard_transmit_request_n),
  .smartcard_receive_request_n(smartcard_receive_request_n),
  .uart_a_request(uart_a_request), .uart_b_request(uart_b_request),
  .board_mcu_request_n(board_mcu_request_n), .usb_power_request(usb_power_request),
  .card_slot_request_n(card_slot_request_n), .graphics_request_n(graphics_request_n),
  .usb_host_request_n(usb_host_request_n), .interrupt_level_code(interrupt_level_code),
  .pci_line_a_n(pci_line_a_n), .pci_line_b_n(pci_line_b_n), .pci_line_c_n(pci_line_c_n));
